/* File: hw/rx_status_pins.sv */
// receive buffer status registers and buffer-full pin logic
// What this block does
// - on a receive buffer 1 load the winning filter index 0 to 5 is stored in control bits 2..0.
// - control bit 3 of buffer 1 is set for a remote request and cleared otherwise on each load.
// - pin control bits 7 and 6 read zero and ignore writes.
// - in output mode pin 1 drives control bit 5, which reads zero in interrupt mode.
// - in output mode pin 0 drives control bit 4, which reads zero in interrupt mode.
// - with enable bit 3 clear pin 1 floats, otherwise it follows its mode bit.
// - with enable bit 2 clear pin 0 floats, otherwise it follows its mode bit.
// - with mode bit 1 set pin 1 signals an interrupt when buffer 1 is loaded, else is an output.
// - with mode bit 0 set pin 0 signals an interrupt when buffer 0 is loaded, else is an output.
// - identifier bits 10..3 land in each buffer's identifier-high register, bit 10 at bit 7.
// - identifier bits 2..0 land in bits 7..5 of each buffer's identifier-low register.
`timescale 1ns/1ps
module rx_status_pins
	import rx_status_pkg::*;
#(
	parameter int N_FILTERS = 6
) (
	input  wire logic                                i_clock,
	input  wire logic                                i_rst,
	// register port
	input  wire logic                                i_reg_wr,
	input  wire logic                                i_reg_rd,
	input  wire logic [rx_status_pkg::ADDR_W-1:0]    i_reg_addr,
	input  wire logic [rx_status_pkg::DATA_W-1:0]    i_reg_wdata,
	output logic      [rx_status_pkg::DATA_W-1:0]    o_reg_rdata,
	// buffer load events from the receive path
	input  wire logic                                i_rx0_load,
	input  wire logic                                i_rx1_load,
	input  wire logic [rx_status_pkg::SID_W-1:0]     i_rx_sid,
	input  wire logic                                i_rx_remote,
	input  wire logic [rx_status_pkg::FILT_W-1:0]    i_rx_filter,
	// full flags as held by the interrupt flag register
	input  wire logic                                i_rx0_full,
	input  wire logic                                i_rx1_full,
	// buffer-full pins
	output logic                                     o_buffer0_full_pin,
	output logic                                     o_buffer0_full_pin_oe,
	output logic                                     o_buffer1_full_pin,
	output logic                                     o_buffer1_full_pin_oe
);
	import rx_status_pkg::*;

	initial begin
		if (N_FILTERS != 6) $error("rx_status_pins: six acceptance filters expected");
	end

	logic [7:0]        pin_ctrl_q;
	logic [FILT_W-1:0] winning_filter_index_q;
	logic              remote_request_received_q;
	logic [7:0]        sidh0;
	logic [7:0]        sidl0;
	logic [7:0]        sidh1;
	logic [7:0]        sidl1;
	logic [7:0]        pin_ctrl_view;
	logic [7:0]        rx1_ctrl_view;
	logic [7:0]        rdata_d;
	logic              pin0_irq_active;
	logic              pin1_irq_active;

	// pin control writes, unimplemented bits dropped
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pin_ctrl_q <= PIN_CTRL_RESET;
		end else if (i_reg_wr && i_reg_addr == ADDR_PIN_CTRL) begin
			pin_ctrl_q <= i_reg_wdata & PIN_CTRL_MASK;
		end
	end

	// buffer 1 filter hit and remote flag, reloaded per message
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			winning_filter_index_q    <= '0;
			remote_request_received_q <= 1'b0;
		end else if (i_rx1_load) begin
			winning_filter_index_q    <= i_rx_filter;
			remote_request_received_q <= i_rx_remote;
		end
	end

	// identifier stores, one per buffer
	rx_id_store #(.SID_W(SID_W)) u_id0 (
		.i_clock    (i_clock),
		.i_rst      (i_rst),
		.i_load     (i_rx0_load),
		.i_sid      (i_rx_sid),
		.o_sid_high (sidh0),
		.o_sid_low  (sidl0)
	);
	rx_id_store #(.SID_W(SID_W)) u_id1 (
		.i_clock    (i_clock),
		.i_rst      (i_rst),
		.i_load     (i_rx1_load),
		.i_sid      (i_rx_sid),
		.o_sid_high (sidh1),
		.o_sid_low  (sidl1)
	);

	// read views: state bits masked in interrupt mode
	always_comb begin
		pin_ctrl_view = pin_ctrl_q;
		if (pin_ctrl_q[BIT_P1_INT]) begin
			pin_ctrl_view[BIT_P1_VAL] = 1'b0;
		end
		if (pin_ctrl_q[BIT_P0_INT]) begin
			pin_ctrl_view[BIT_P0_VAL] = 1'b0;
		end
		rx1_ctrl_view = ZERO_BYTE;
		rx1_ctrl_view[BIT_RTR] = remote_request_received_q;
		rx1_ctrl_view[FILT_LSB +: FILT_W] = winning_filter_index_q;
	end

	// read decode, unmapped addresses read zero
	always_comb begin
		case (i_reg_addr)
			ADDR_PIN_CTRL: rdata_d = pin_ctrl_view;
			ADDR_RX0_SIDH: rdata_d = sidh0;
			ADDR_RX0_SIDL: rdata_d = sidl0;
			ADDR_RX1_CTRL: rdata_d = rx1_ctrl_view;
			ADDR_RX1_SIDH: rdata_d = sidh1;
			ADDR_RX1_SIDL: rdata_d = sidl1;
			default:       rdata_d = ZERO_BYTE;
		endcase
	end

	// registered read data, held between reads
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_reg_rdata <= ZERO_BYTE;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rdata_d;
		end
	end

	// interrupt level tracks the full flag set by a load
	assign pin0_irq_active = i_rx0_full;
	assign pin1_irq_active = i_rx1_full;

	// pin drive and enables
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_buffer0_full_pin    <= 1'b1;
			o_buffer0_full_pin_oe <= 1'b0;
			o_buffer1_full_pin    <= 1'b1;
			o_buffer1_full_pin_oe <= 1'b0;
		end else begin
			o_buffer0_full_pin_oe <= pin_ctrl_q[BIT_P0_EN];
			o_buffer1_full_pin_oe <= pin_ctrl_q[BIT_P1_EN];
			if (pin_ctrl_q[BIT_P0_INT]) begin
				o_buffer0_full_pin <= ~pin0_irq_active;
			end else begin
				o_buffer0_full_pin <= pin_ctrl_q[BIT_P0_VAL];
			end
			if (pin_ctrl_q[BIT_P1_INT]) begin
				o_buffer1_full_pin <= ~pin1_irq_active;
			end else begin
				o_buffer1_full_pin <= pin_ctrl_q[BIT_P1_VAL];
			end
		end
	end

	// checks: buffer 1 filter hit and remote flag
	chk_filter_capture: assert property (@(posedge i_clock) disable iff (i_rst)
		i_rx1_load |=> winning_filter_index_q == $past(i_rx_filter))
		else $error("filter index not captured");

	chk_filter_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_rx1_load |=> $stable(winning_filter_index_q))
		else $error("filter index changed without a load");

	chk_filter_range: assert property (@(posedge i_clock) disable iff (i_rst)
		winning_filter_index_q <= FILT_MAX)
		else $error("filter index beyond last filter");

	chk_remote_capture: assert property (@(posedge i_clock) disable iff (i_rst)
		i_rx1_load |=> remote_request_received_q == $past(i_rx_remote))
		else $error("remote flag not captured");

	chk_remote_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_rx1_load |=> $stable(remote_request_received_q))
		else $error("remote flag changed without a load");

	chk_rdata_rx1ctrl: assert property (@(posedge i_clock) disable iff (i_rst)
		i_reg_rd && i_reg_addr == ADDR_RX1_CTRL |=> o_reg_rdata == {4'h0,
		$past(remote_request_received_q), $past(winning_filter_index_q)})
		else $error("buffer 1 control read wrong");

	// checks: pin control register
	chk_unimpl_zero: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[7:6] == 2'b00)
		else $error("unimplemented pin control bits set");

	chk_view_upper: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_view[7:6] == 2'b00)
		else $error("unimplemented pin control bits read back");

	chk_wr_mask: assert property (@(posedge i_clock) disable iff (i_rst)
		i_reg_wr && i_reg_addr == ADDR_PIN_CTRL
		|=> pin_ctrl_q == ($past(i_reg_wdata) & PIN_CTRL_MASK))
		else $error("pin control write not taken");

	chk_ctrl_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		!(i_reg_wr && i_reg_addr == ADDR_PIN_CTRL) |=> $stable(pin_ctrl_q))
		else $error("pin control changed without a write");

	chk_rdata_ctrl: assert property (@(posedge i_clock) disable iff (i_rst)
		i_reg_rd && i_reg_addr == ADDR_PIN_CTRL |=> o_reg_rdata == $past(pin_ctrl_view))
		else $error("pin control read wrong");

	chk_rdata_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data changed without a read");

	chk_view_mask1: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[BIT_P1_INT] |-> !pin_ctrl_view[BIT_P1_VAL])
		else $error("pin 1 state bit visible in interrupt mode");

	chk_view_mask0: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[BIT_P0_INT] |-> !pin_ctrl_view[BIT_P0_VAL])
		else $error("pin 0 state bit visible in interrupt mode");

	// checks: pin drive, skipping the edge that leaves reset
	chk_pin1_output: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_rst && !pin_ctrl_q[BIT_P1_INT] ##1 !pin_ctrl_q[BIT_P1_INT]
		|-> o_buffer1_full_pin == $past(pin_ctrl_q[BIT_P1_VAL]))
		else $error("pin 1 output value wrong");

	chk_pin0_output: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_rst && !pin_ctrl_q[BIT_P0_INT] ##1 !pin_ctrl_q[BIT_P0_INT]
		|-> o_buffer0_full_pin == $past(pin_ctrl_q[BIT_P0_VAL]))
		else $error("pin 0 output value wrong");

	chk_pin1_float: assert property (@(posedge i_clock) disable iff (i_rst)
		!pin_ctrl_q[BIT_P1_EN] |=> !o_buffer1_full_pin_oe)
		else $error("pin 1 driven while disabled");

	chk_pin1_on: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[BIT_P1_EN] |=> o_buffer1_full_pin_oe)
		else $error("pin 1 not driven while enabled");

	chk_pin0_float: assert property (@(posedge i_clock) disable iff (i_rst)
		!pin_ctrl_q[BIT_P0_EN] |=> !o_buffer0_full_pin_oe)
		else $error("pin 0 driven while disabled");

	chk_pin0_on: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[BIT_P0_EN] |=> o_buffer0_full_pin_oe)
		else $error("pin 0 not driven while enabled");

	// checks: interrupt level on the pins
	chk_pin1_irq: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[BIT_P1_INT] && i_rx1_full |=> !o_buffer1_full_pin)
		else $error("pin 1 interrupt not asserted");

	chk_pin0_irq: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[BIT_P0_INT] && i_rx0_full |=> !o_buffer0_full_pin)
		else $error("pin 0 interrupt not asserted");

	chk_irq_release: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[BIT_P0_INT] && !i_rx0_full |=> o_buffer0_full_pin)
		else $error("pin 0 interrupt not released");

	chk_irq1_release: assert property (@(posedge i_clock) disable iff (i_rst)
		pin_ctrl_q[BIT_P1_INT] && !i_rx1_full |=> o_buffer1_full_pin)
		else $error("pin 1 interrupt not released");

	// checks: identifier registers of both buffers
	chk_sid_high: assert property (@(posedge i_clock) disable iff (i_rst)
		i_rx0_load |=> sidh0 == $past(i_rx_sid[10:3]))
		else $error("identifier high wrong");

	chk_sid_high1: assert property (@(posedge i_clock) disable iff (i_rst)
		i_rx1_load |=> sidh1 == $past(i_rx_sid[10:3]))
		else $error("buffer 1 identifier high wrong");

	chk_sid_hold0: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_rx0_load |=> $stable(sidh0))
		else $error("buffer 0 identifier changed without a load");

	chk_rdata_sidh0: assert property (@(posedge i_clock) disable iff (i_rst)
		i_reg_rd && i_reg_addr == ADDR_RX0_SIDH |=> o_reg_rdata == $past(sidh0))
		else $error("buffer 0 identifier high read wrong");

	chk_rdata_sidh1: assert property (@(posedge i_clock) disable iff (i_rst)
		i_reg_rd && i_reg_addr == ADDR_RX1_SIDH |=> o_reg_rdata == $past(sidh1))
		else $error("buffer 1 identifier high read wrong");

	chk_sid_low: assert property (@(posedge i_clock) disable iff (i_rst)
		i_rx1_load |=> sidl1[7:5] == $past(i_rx_sid[2:0]))
		else $error("identifier low wrong");

	chk_sid_low0: assert property (@(posedge i_clock) disable iff (i_rst)
		i_rx0_load |=> sidl0[7:5] == $past(i_rx_sid[2:0]))
		else $error("buffer 0 identifier low wrong");

	chk_sidl_pad0: assert property (@(posedge i_clock) disable iff (i_rst)
		sidl0[4:0] == 5'h00)
		else $error("buffer 0 identifier low filler set");

	chk_sidl_pad1: assert property (@(posedge i_clock) disable iff (i_rst)
		sidl1[4:0] == 5'h00)
		else $error("buffer 1 identifier low filler set");

	chk_rdata_sidl1: assert property (@(posedge i_clock) disable iff (i_rst)
		i_reg_rd && i_reg_addr == ADDR_RX1_SIDL |=> o_reg_rdata == $past(sidl1))
		else $error("buffer 1 identifier low read wrong");
endmodule

/* File: hw/rx_status_pkg.sv */
// constants for the receive buffer status and buffer-full pin block
package rx_status_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam int          SID_W           = 11;
	localparam int          FILT_W          = 3;
	// register addresses
	localparam logic [7:0]  ADDR_PIN_CTRL   = 8'h0c;
	localparam logic [7:0]  ADDR_RX0_SIDH   = 8'h61;
	localparam logic [7:0]  ADDR_RX0_SIDL   = 8'h62;
	localparam logic [7:0]  ADDR_RX1_CTRL   = 8'h70;
	localparam logic [7:0]  ADDR_RX1_SIDH   = 8'h71;
	localparam logic [7:0]  ADDR_RX1_SIDL   = 8'h72;
	// pin control field positions
	localparam int          BIT_P1_VAL      = 5;
	localparam int          BIT_P0_VAL      = 4;
	localparam int          BIT_P1_EN       = 3;
	localparam int          BIT_P0_EN       = 2;
	localparam int          BIT_P1_INT      = 1;
	localparam int          BIT_P0_INT      = 0;
	localparam logic [7:0]  PIN_CTRL_MASK   = 8'h3f;
	localparam logic [7:0]  PIN_CTRL_RESET  = 8'h00;
	// rx1 control field positions
	localparam int          BIT_RTR         = 3;
	localparam int          FILT_LSB        = 0;
	localparam logic [2:0]  FILT_MAX        = 3'h5;
	// identifier split
	localparam int          SID_HI_LSB      = 3;
	localparam int          SIDL_LSB        = 5;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
endpackage

/* File: hw/rx_id_store.sv */
// identifier store for one receive buffer, registered identifier bytes
`timescale 1ns/1ps
module rx_id_store #(
	parameter int SID_W = 11
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	input  wire logic             i_load,
	input  wire logic [SID_W-1:0] i_sid,
	output logic      [7:0]       o_sid_high,
	output logic      [7:0]       o_sid_low
);
	import rx_status_pkg::*;

	initial begin
		if (SID_W != 11) $error("rx_id_store: identifier width must be 11");
	end

	// capture identifier on each load
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_sid_high <= ZERO_BYTE;
			o_sid_low  <= ZERO_BYTE;
		end else if (i_load) begin
			o_sid_high <= i_sid[SID_W-1:SID_HI_LSB];
			o_sid_low  <= {i_sid[SID_HI_LSB-1:0], 5'h00};
		end
	end
endmodule

/* File: testbench/host_pin_model.sv */
// host-side view of the two buffer-full pins, with pull-ups
`timescale 1ns/1ps
module host_pin_model (
	input  wire logic i_pin0,
	input  wire logic i_pin0_oe,
	input  wire logic i_pin1,
	input  wire logic i_pin1_oe,
	output logic      o_level0,
	output logic      o_level1
);
	// a released pin floats up to the pull-up level
	assign o_level0 = i_pin0_oe ? i_pin0 : 1'b1;
	assign o_level1 = i_pin1_oe ? i_pin1 : 1'b1;
endmodule

/* File: testbench/rx_status_pins_test.sv */
// self-checking bench for the receive status and buffer-full pin block
`timescale 1ns/1ps
module rx_status_pins_test;
	import rx_status_pkg::*;
	logic        i_clock, i_rst, i_reg_wr, i_reg_rd, i_rx0_load, i_rx1_load;
	logic        i_rx_remote, i_rx0_full, i_rx1_full, p0, p0_oe, p1, p1_oe, lvl0, lvl1;
	logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, rd_v;
	logic [10:0] i_rx_sid;
	logic [2:0]  i_rx_filter;
	int          n_fail = 0;
	int          checks = 0;
	rx_status_pins DUT (.i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .i_rx0_load(i_rx0_load), .i_rx1_load(i_rx1_load),
		.i_rx_sid(i_rx_sid), .i_rx_remote(i_rx_remote), .i_rx_filter(i_rx_filter),
		.i_rx0_full(i_rx0_full), .i_rx1_full(i_rx1_full), .o_buffer0_full_pin(p0),
		.o_buffer0_full_pin_oe(p0_oe), .o_buffer1_full_pin(p1), .o_buffer1_full_pin_oe(p1_oe));
	host_pin_model host (.i_pin0(p0), .i_pin0_oe(p0_oe), .i_pin1(p1), .i_pin1_oe(p1_oe),
		.o_level0(lvl0), .o_level1(lvl1));
	// compare helpers
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_pins(input logic [3:0] exp);
		repeat (2) @(posedge i_clock);
		#1 cmp({4'h0, p1_oe, lvl1, p0_oe, lvl0}, {4'h0, exp});
	endtask
	// register access, one strobe cycle each
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clock);
		i_reg_rd <= 1'b0;
		#1 cmp(o_reg_rdata, exp);
	endtask
	// one message load pulse into buffer 0 or 1
	task automatic load(input logic b1, input logic [10:0] standard_identifier, input logic rem,
		input logic [2:0] f);
		@(posedge i_clock);
		i_rx0_load <= ~b1;
		i_rx1_load <= b1;
		i_rx_sid <= standard_identifier;
		i_rx_remote <= rem;
		i_rx_filter <= f;
		@(posedge i_clock);
		i_rx0_load <= 1'b0;
		i_rx1_load <= 1'b0;
	endtask
	task automatic test_reset;
		rd_cmp(ADDR_PIN_CTRL, 8'h00);
		cmp_pins(4'b0101);
	endtask
	task automatic test_int_mode;
		wr(ADDR_PIN_CTRL, 8'hff);
		rd_cmp(ADDR_PIN_CTRL, 8'h0f);
		cmp_pins(4'b1111);
		@(posedge i_clock);
		i_rx1_full <= 1'b1;
		cmp_pins(4'b1011);
		@(posedge i_clock);
		i_rx0_full <= 1'b1;
		i_rx1_full <= 1'b0;
		cmp_pins(4'b1110);
		@(posedge i_clock);
		i_rx0_full <= 1'b0;
	endtask
	task automatic test_output_mode;
		wr(ADDR_PIN_CTRL, 8'h2c);
		rd_cmp(ADDR_PIN_CTRL, 8'h2c);
		cmp_pins(4'b1110);
		wr(ADDR_PIN_CTRL, 8'h1c);
		rd_cmp(ADDR_PIN_CTRL, 8'h1c);
		cmp_pins(4'b1011);
		wr(ADDR_PIN_CTRL, 8'h20);
		cmp_pins(4'b0101);
	endtask
	task automatic test_loads;
		logic [10:0] standard_identifier;
		for (int f = 0; f < 6; f++) begin
			standard_identifier = 11'h123 + 11'(f * 299);
			load(1'b1, standard_identifier, f[0], 3'(f));
			rd_cmp(ADDR_RX1_CTRL, {4'h0, f[0], 3'(f)});
			rd_cmp(ADDR_RX1_SIDH, standard_identifier[10:3]);
			rd_cmp(ADDR_RX1_SIDL, {standard_identifier[2:0], 5'h00});
		end
		load(1'b0, 11'h4b6, 1'b1, 3'h2);
		rd_cmp(ADDR_RX0_SIDH, 8'h96);
		rd_cmp(ADDR_RX0_SIDL, 8'hc0);
		rd_cmp(ADDR_RX1_CTRL, {4'h0, 1'b1, 3'h5});
		wr(ADDR_RX1_SIDH, 8'h00);
		rd_cmp(ADDR_RX1_SIDH, standard_identifier[10:3]);
		rd_cmp(8'h33, 8'h00);
	endtask
	// verdict and end of run
	task automatic give_verdict;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	// watchdog, far beyond the hundred or so cycles the tests need
	initial begin
		#100000;
		n_fail++;
		give_verdict();
	end
	initial begin
		{i_rst, i_reg_wr, i_reg_rd, i_rx0_load, i_rx1_load} = 5'b10000;
		{i_rx_remote, i_rx0_full, i_rx1_full, i_reg_addr, i_reg_wdata} = '0;
		i_rx_sid = '0;
		i_rx_filter = '0;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		test_reset();
		test_int_mode();
		test_output_mode();
		test_loads();
		give_verdict();
	end
endmodule
